// *** core/csub_pkg.sv ***
// Contract
// - hold two 192-bit status blocks plus 384 user bits
// - status passes input, middle, output buffers
// - byte msb is earliest serial bit
// - middle status buffer host readable and writable
// - interrupt on each enabled buffer transfer
// - inhibit bits suppress each transfer kind
// - input transfers on input timebase, output on output
// - professional channel A block gets checksum byte, copied to B
// - reservation keeps first five middle bytes
// - middle buffer is 24 words, A high byte
// - one-byte read picks channel A or B
// - one-byte write stores both channels
// - two-byte access sends A byte then B
// - user mode one transmits all zeros
// - user mode two buffers through three stores
// - user access two-byte, bits interleaved A7 B7
// - user byte msb first, first byte first
package csub_pkg;
    localparam int unsigned CSUB_WORDS = 24;
    localparam int unsigned CSUB_RESERVED_BYTES = 5;
    localparam int unsigned CSUB_FIFO_DEPTH = 8;
    localparam logic [7:0] CSUB_CS_BASE = 8'h20;
    localparam logic [7:0] CSUB_US_BASE = 8'h38;
    localparam logic [7:0] CSUB_CTRL_ADDR = 8'h10;
    localparam logic [7:0] CSUB_INTEN_ADDR = 8'h11;
    localparam logic [7:0] CSUB_STAT_ADDR = 8'h12;
    localparam int unsigned CSUB_CTRL_INH_IN = 0;
    localparam int unsigned CSUB_CTRL_INH_OUT = 1;
    localparam int unsigned CSUB_CTRL_RESERVE = 2;
    localparam int unsigned CSUB_CTRL_ONE_BYTE = 3;
    localparam int unsigned CSUB_CTRL_SEL_B = 4;
    localparam int unsigned CSUB_CTRL_UMODE = 5;
    localparam logic [7:0] CSUB_CTRL_RESET = 8'h00;
    localparam logic [7:0] CSUB_CRC_INIT = 8'hff;
    localparam logic [7:0] CSUB_CRC_POLY = 8'h1d;
endpackage

// *** core/csub_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module csub_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    assign o_ready = 32'(cnt_q) != DEPTH;
    assign o_valid = cnt_q != '0;
    assign o_data = mem_q[rd_q];
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= (32'(wr_q) == DEPTH - 1) ? '0 : wr_q + 1'b1;
            if (pop)
                rd_q <= (32'(rd_q) == DEPTH - 1) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_q[wr_q] <= i_data;
    end
endmodule
`default_nettype wire

// *** core/csub_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module csub_buffer
    import csub_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    // receiver side: one status word and one user word per step
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire logic [15:0] i_rx_cs,
    input wire logic [15:0] i_rx_us,
    input wire logic i_rx_block_end,
    input wire logic i_tx_block_start,
    input wire logic [4:0] i_tx_index,
    output logic [15:0] o_tx_cs,
    output logic [15:0] o_tx_us,
    // host port: byte access
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_addr,
    input wire logic [7:0] i_host_wdata,
    output logic [7:0] o_host_rdata,
    output logic o_irq_in_xfer,
    output logic o_irq_out_xfer
);
    logic [15:0] d_cs_q [CSUB_WORDS];
    logic [15:0] d_us_q [CSUB_WORDS];
    logic [15:0] e_cs_q [CSUB_WORDS];
    logic [15:0] e_us_q [CSUB_WORDS];
    logic [15:0] f_cs_q [CSUB_WORDS];
    logic [15:0] f_us_q [CSUB_WORDS];
    logic [4:0] rx_idx_q;
    logic [7:0] ctrl_q;
    logic [1:0] inten_q;
    logic [1:0] stat_q;
    logic byte2_q;
    logic [7:0] hold_q;
    logic [7:0] rdata_q;
    logic [15:0] ff_data;
    logic ff_valid;
    logic [7:0] crc;

    // status words from the receiver queue here so a burst never stalls the serial path
    csub_fifo #(.WIDTH(16), .DEPTH(CSUB_FIFO_DEPTH)) u_cs_fifo (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_rx_valid), .o_ready(o_rx_ready),
        .i_data(i_rx_cs), .o_valid(ff_valid), .i_ready(1'b1), .o_data(ff_data)
    );
    logic [15:0] us_pipe_q;
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            us_pipe_q <= 16'h0000;
        else if (i_rx_valid && o_rx_ready)
            us_pipe_q <= i_rx_us;
    end

    wire inh_in = ctrl_q[CSUB_CTRL_INH_IN];
    wire inh_out = ctrl_q[CSUB_CTRL_INH_OUT];
    wire one_byte = ctrl_q[CSUB_CTRL_ONE_BYTE];
    wire do_in = i_rx_block_end && !inh_in;
    wire do_out = i_tx_block_start && !inh_out;
    wire cs_hit = (i_host_addr >= CSUB_CS_BASE) && (i_host_addr < CSUB_CS_BASE + 8'h18);
    wire us_hit = (i_host_addr >= CSUB_US_BASE) && (i_host_addr < CSUB_US_BASE + 8'h18);
    wire [4:0] cs_w = 5'(i_host_addr - CSUB_CS_BASE);
    wire [4:0] us_w = 5'(i_host_addr - CSUB_US_BASE);
    wire professional_format = e_cs_q[0][15];
    wire umode2 = ctrl_q[CSUB_CTRL_UMODE];

    // checksum over bytes 0..22 of channel A, msb-first serial order
    always_comb
    begin
        crc = CSUB_CRC_INIT;
        for (int w = 0; w < 23; w++)
            for (int b = 7; b >= 0; b--)
                crc = (crc[7] ^ e_cs_q[w][8+b]) ? ((crc << 1) ^ CSUB_CRC_POLY) : (crc << 1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rx_idx_q <= '0;
            ctrl_q <= CSUB_CTRL_RESET;
            inten_q <= '0;
            stat_q <= '0;
            byte2_q <= 1'b0;
            hold_q <= 8'h00;
            rdata_q <= 8'h00;
            for (int i = 0; i < CSUB_WORDS; i++)
            begin
                d_cs_q[i] <= 16'h0000;
                d_us_q[i] <= 16'h0000;
                e_cs_q[i] <= 16'h0000;
                e_us_q[i] <= 16'h0000;
                f_cs_q[i] <= 16'h0000;
                f_us_q[i] <= 16'h0000;
            end
        end
        else
        begin
            if (ff_valid)
            begin
                d_cs_q[rx_idx_q] <= ff_data;
                d_us_q[rx_idx_q] <= us_pipe_q;
                rx_idx_q <= (rx_idx_q == 5'(CSUB_WORDS - 1)) ? '0 : rx_idx_q + 1'b1;
            end
            if (i_rx_block_end)
                rx_idx_q <= '0;
            if (do_in)
                for (int i = 0; i < CSUB_WORDS; i++)
                begin
                    if (!(ctrl_q[CSUB_CTRL_RESERVE] && i < 3))
                        e_cs_q[i] <= d_cs_q[i];
                    else if (i == 2)
                        e_cs_q[i][7:0] <= d_cs_q[i][7:0];
                    e_us_q[i] <= d_us_q[i];
                end
            // reserve keeps 5 bytes: words 0,1 whole, channel A byte of word 2
            if (do_out)
                for (int i = 0; i < CSUB_WORDS; i++)
                begin
                    f_cs_q[i] <= e_cs_q[i];
                    f_us_q[i] <= umode2 ? e_us_q[i] : 16'h0000;
                end
            if (do_out && professional_format)
                f_cs_q[23] <= {crc, crc};
            stat_q <= {stat_q[1] | do_out, stat_q[0] | do_in};
            if (i_host_wr)
            begin
                if (i_host_addr == CSUB_CTRL_ADDR)
                    ctrl_q <= i_host_wdata;
                else if (i_host_addr == CSUB_INTEN_ADDR)
                    inten_q <= i_host_wdata[1:0];
                else if (i_host_addr == CSUB_STAT_ADDR)
                    stat_q <= (stat_q & ~i_host_wdata[1:0]) | {do_out, do_in};
                else if (cs_hit && one_byte)
                    e_cs_q[cs_w] <= {i_host_wdata, i_host_wdata};
                else if ((cs_hit || us_hit) && !byte2_q)
                begin
                    hold_q <= i_host_wdata;
                    byte2_q <= 1'b1;
                end
                else if (cs_hit)
                begin
                    e_cs_q[cs_w] <= {hold_q, i_host_wdata};
                    byte2_q <= 1'b0;
                end
                else if (us_hit)
                begin
                    e_us_q[us_w] <= {hold_q, i_host_wdata};
                    byte2_q <= 1'b0;
                end
            end
            if (i_host_rd)
            begin
                if (i_host_addr == CSUB_CTRL_ADDR)
                    rdata_q <= ctrl_q;
                else if (i_host_addr == CSUB_STAT_ADDR)
                    rdata_q <= {6'b0, stat_q};
                else if (cs_hit && one_byte)
                    rdata_q <= ctrl_q[CSUB_CTRL_SEL_B] ? e_cs_q[cs_w][7:0] : e_cs_q[cs_w][15:8];
                else if (cs_hit)
                begin
                    rdata_q <= byte2_q ? e_cs_q[cs_w][7:0] : e_cs_q[cs_w][15:8];
                    byte2_q <= !byte2_q;
                end
                else if (us_hit)
                begin
                    rdata_q <= byte2_q ? e_us_q[us_w][7:0] : e_us_q[us_w][15:8];
                    byte2_q <= !byte2_q;
                end
                else
                    rdata_q <= 8'h00;
            end
        end
    end

    assign o_host_rdata = rdata_q;
    assign o_tx_cs = f_cs_q[i_tx_index];
    assign o_tx_us = umode2 ? f_us_q[i_tx_index] : 16'h0000;
    assign o_irq_in_xfer = stat_q[0] && inten_q[0];
    assign o_irq_out_xfer = stat_q[1] && inten_q[1];

    inh_skip_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rx_block_end && inh_in) |=> !$rose(stat_q[0]) || $past(i_host_wr))
        else $error("inhibited input transfer flagged");
    zero_user_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !umode2 |-> o_tx_us == 16'h0000)
        else $error("user bits not zero in mode one");
    in_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        do_in |=> stat_q[0])
        else $error("input transfer not flagged");
    out_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        do_out |=> stat_q[1])
        else $error("output transfer not flagged");
    out_copy_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        do_out |=> f_cs_q[5] == $past(e_cs_q[5]))
        else $error("output block not copied");
    reserve_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (do_in && ctrl_q[CSUB_CTRL_RESERVE] && !i_host_wr) |=> $stable(e_cs_q[0]))
        else $error("reserved bytes overwritten");
    one_wr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_host_wr && cs_hit && one_byte && !do_in) |=> e_cs_q[$past(cs_w)] == {2{$past(i_host_wdata)}})
        else $error("one-byte write not doubled");
    crc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (do_out && professional_format) |=> f_cs_q[23][15:8] == $past(crc))
        else $error("checksum byte wrong");
endmodule
`default_nettype wire

// *** bench/csub_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module csub_rx_model (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_seed,
    input wire logic i_ready,
    output logic o_valid,
    output logic [15:0] o_cs,
    output logic [15:0] o_us,
    output logic o_block_end,
    output logic o_done
);
    // released lines show inverted data so stale words never pass as fresh
    initial
    begin
        {o_valid, o_block_end, o_done, o_cs, o_us} = '0;
        forever
        begin
            @(posedge i_go);
            o_done = 1'b0;
            for (int i = 0; i < 24; i++)
            begin
                @(negedge i_clk);
                o_valid = 1'b1;
                o_cs = {i_seed + 8'(i), ~(i_seed + 8'(i))};
                o_us = {i_seed, 8'(i)};
                while (!i_ready)
                    @(negedge i_clk);
                @(posedge i_clk);
                @(negedge i_clk);
                o_valid = 1'b0;
                o_cs = ~o_cs;
                o_us = ~o_us;
            end
            repeat (6) @(negedge i_clk);
            o_block_end = 1'b1;
            @(negedge i_clk);
            o_block_end = 1'b0;
            o_done = 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** bench/tb_csub_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_csub_buffer;
    import csub_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, go = 1'b0, rv, rbe, rdy, done, ts = 1'b0;
    logic hwr = 1'b0, hrd = 1'b0, iq_in, iq_out;
    logic [15:0] rcs, rus, tcs, tus;
    logic [7:0] seed = 8'h00, ha = 8'h00, hd = 8'h00, hq, b0, b1;
    logic [4:0] ti = 5'h00;
    int err_total = 0, total_checks = 0, cyc = 0;
    csub_buffer dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(rv), .o_rx_ready(rdy), .i_rx_cs(rcs),
        .i_rx_us(rus), .i_rx_block_end(rbe), .i_tx_block_start(ts), .i_tx_index(ti), .o_tx_cs(tcs),
        .o_tx_us(tus), .i_host_wr(hwr), .i_host_rd(hrd), .i_host_addr(ha), .i_host_wdata(hd),
        .o_host_rdata(hq), .o_irq_in_xfer(iq_in), .o_irq_out_xfer(iq_out));
    csub_rx_model rx (.i_clk(i_clk), .i_go(go), .i_seed(seed), .i_ready(rdy), .o_valid(rv), .o_cs(rcs),
        .o_us(rus), .o_block_end(rbe), .o_done(done));
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard, generous against the few blocks sent
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        {hwr, ha, hd} = {1'b1, a, d};
        @(negedge i_clk);
        {hwr, ha, hd} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        {hrd, ha} = {1'b1, a};
        @(negedge i_clk);
        hrd = 1'b0;
        d = hq;
    endtask
    task automatic chk_word(input logic [7:0] a, input logic [15:0] exp);
        rd(a, b0);
        rd(a, b1);
        chk({b0, b1}, exp);
    endtask
    task automatic chk_tx(input logic [4:0] i, input logic [15:0] ecs, input logic [15:0] eus);
        @(negedge i_clk);
        ti = i;
        #1;
        chk(tcs, ecs);
        chk(tus, eus);
    endtask
    task automatic block(input logic [7:0] s);
        @(negedge i_clk);
        {seed, go} = {s, 1'b1};
        @(negedge i_clk);
        go = 1'b0;
        for (int k = 0; k < 400 && done !== 1'b1; k++)
            @(negedge i_clk);
        @(negedge i_clk);
    endtask
    task automatic txb;
        @(negedge i_clk);
        ts = 1'b1;
        @(negedge i_clk);
        ts = 1'b0;
        @(negedge i_clk);
    endtask
    function automatic logic [7:0] crc8;
        logic [7:0] c;
        c = CSUB_CRC_INIT;
        for (int i = 0; i < 23; i++)
        begin
            c = c ^ (i == 0 ? 8'h80 : 8'(i));
            for (int b = 0; b < 8; b++)
                c = c[7] ? ((c << 1) ^ CSUB_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction
    initial
    begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        rd(CSUB_CTRL_ADDR, b0);
        chk({8'h00, b0}, {8'h00, CSUB_CTRL_RESET});
        chk_word(CSUB_CS_BASE, 16'h0000);
        rd(8'h7f, b0);
        chk({8'h00, b0}, 16'h0000);
        $display("reset test done");
        wr(CSUB_CS_BASE + 8'h03, 8'ha1);
        wr(CSUB_CS_BASE + 8'h03, 8'hb2);
        chk_word(CSUB_CS_BASE + 8'h03, 16'ha1b2);
        wr(CSUB_CTRL_ADDR, 8'h08);
        rd(CSUB_CS_BASE + 8'h03, b0);
        chk({8'h00, b0}, 16'h00a1);
        wr(CSUB_CTRL_ADDR, 8'h18);
        rd(CSUB_CS_BASE + 8'h03, b0);
        chk({8'h00, b0}, 16'h00b2);
        wr(CSUB_CS_BASE + 8'h04, 8'h3c);
        wr(CSUB_CTRL_ADDR, 8'h00);
        chk_word(CSUB_CS_BASE + 8'h04, 16'h3c3c);
        $display("host access test done");
        wr(CSUB_INTEN_ADDR, 8'h03);
        block(8'h10);
        chk({15'h0000, iq_in}, 16'h0001);
        chk({15'h0000, iq_out}, 16'h0000);
        chk_word(CSUB_CS_BASE + 8'h05, 16'h15ea);
        chk_word(CSUB_CS_BASE + 8'h17, 16'h27d8);
        wr(CSUB_STAT_ADDR, 8'h01);
        chk({15'h0000, iq_in}, 16'h0000);
        wr(CSUB_CTRL_ADDR, 8'h01);
        block(8'h40);
        chk_word(CSUB_CS_BASE + 8'h05, 16'h15ea);
        wr(CSUB_CTRL_ADDR, 8'h00);
        block(8'h40);
        chk_word(CSUB_CS_BASE + 8'h05, 16'h45ba);
        $display("input transfer test done");
        wr(CSUB_CTRL_ADDR, 8'h04);
        wr(CSUB_CS_BASE, 8'h11);
        wr(CSUB_CS_BASE, 8'h22);
        block(8'h60);
        chk_word(CSUB_CS_BASE, 16'h1122);
        chk_word(CSUB_CS_BASE + 8'h03, 16'h639c);
        chk_word(CSUB_CS_BASE + 8'h02, 16'h429d);
        $display("reserve test done");
        wr(CSUB_CTRL_ADDR, 8'h02);
        txb();
        chk({15'h0000, iq_out}, 16'h0000);
        chk_tx(5'd3, 16'h0000, 16'h0000);
        wr(CSUB_CTRL_ADDR, 8'h20);
        txb();
        chk({15'h0000, iq_out}, 16'h0001);
        chk_tx(5'd3, 16'h639c, 16'h6003);
        wr(CSUB_CTRL_ADDR, 8'h00);
        txb();
        chk_tx(5'd3, 16'h639c, 16'h0000);
        $display("output transfer test done");
        wr(CSUB_CTRL_ADDR, 8'h08);
        for (int i = 0; i < 24; i++)
            wr(CSUB_CS_BASE + 8'(i), i == 0 ? 8'h80 : 8'(i));
        txb();
        chk_tx(5'd23, {crc8(), crc8()}, 16'h0000);
        $display("checksum test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
